// file: hdl/cssc_pkg.sv
// constants and types of the card supply select and chip select block
// assumes a single 50 MHz clock and pins that are synchronised in the top module
// Operation
// - measure command high time before activating fall
// - high over 30 ms selects 5 V unless a selection pulse follows
// - high under 15 ms selects 3 V
// - select pin: high 5 V, low 3 V, float 1.8 V
// - normal operation only while chip select high
// - chip select low latches reset and command
// - chip select low floats host data line
// - chip select low floats card status output
// - deselect keeps wait and active states and card session
// - clock keeps running while deselected
// - outside session status shows card presence
package cssc_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_MHZ      = 50;
   localparam int unsigned T_5V_US      = 30000;
   localparam int unsigned T_3V_US      = 15000;
   localparam int unsigned T_PMIN_US    = 200;
   localparam int unsigned T_PMAX_US    = 700;
   localparam int unsigned T_HMAX_US    = 15000;
   localparam int unsigned CYC_5V       = T_5V_US * CLK_MHZ;
   localparam int unsigned CYC_3V       = T_3V_US * CLK_MHZ;
   localparam int unsigned CYC_PMIN     = T_PMIN_US * CLK_MHZ;
   localparam int unsigned CYC_PMAX     = T_PMAX_US * CLK_MHZ;
   localparam int unsigned CYC_HMAX     = T_HMAX_US * CLK_MHZ;
   localparam int unsigned CNT_W        = 21;

   // ----------------------------------------------------------------
   // synchroniser bit positions
   // ----------------------------------------------------------------
   localparam int unsigned SI_CMD       = 0;
   localparam int unsigned SI_RST       = 1;
   localparam int unsigned SI_CS        = 2;
   localparam int unsigned SI_SELHI     = 3;
   localparam int unsigned SI_SELLO     = 4;
   localparam int unsigned SI_PRES      = 5;
   localparam int unsigned SI_HIO       = 6;
   localparam int unsigned SI_CIO       = 7;
   localparam int unsigned SI_W         = 8;
   localparam logic [SI_W-1:0] SYNC_RST = 8'hC1;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_WAIT  = 4'h1,
      ST_PULSE = 4'h2,
      ST_SEL   = 4'h4,
      ST_ACT   = 4'h8
   } cssc_state_e;

   typedef enum logic [1:0] {
      VCC_OFF = 2'h0,
      VCC_5V0 = 2'h1,
      VCC_3V0 = 2'h2,
      VCC_1V8 = 2'h3
   } cssc_vcc_e;

   typedef enum logic [1:0] {
      IO_NONE = 2'h0,
      IO_HOST = 2'h1,
      IO_CARD = 2'h2
   } cssc_io_e;

   typedef struct packed {
      logic [SI_W-1:0]  syncA;
      logic [SI_W-1:0]  syncB;
      logic             cmdPrev;
      logic             cmdHeld;
      logic             rstHeld;
      logic [CNT_W-1:0] cnt;
      cssc_state_e      state;
      logic             pend5v;
      cssc_vcc_e        vcc;
      cssc_io_e         ioMaster;
      logic             hostIoOut;
      logic             hostIoOe;
      logic             cardIoOe;
      logic             cardRst;
      logic             statOut;
      logic             statOe;
   } cssc_regs_s;

endpackage

// file: hdl/cssc_top.sv
// supply level choice from command timing or select pin, chip select gating
// assumes pin inputs other than nrst and the pinSelectMode strap are asynchronous; open-drain lines have external pull-ups
`timescale 1ns/1ps
module cssc_top
   import cssc_pkg::*;
#(
   parameter int unsigned CYC_5V_P   = CYC_5V,
   parameter int unsigned CYC_3V_P   = CYC_3V,
   parameter int unsigned CYC_PMIN_P = CYC_PMIN,
   parameter int unsigned CYC_PMAX_P = CYC_PMAX,
   parameter int unsigned CYC_HMAX_P = CYC_HMAX
)(
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       supplyCommandN,
   input  wire logic       cardResetRequest,
   input  wire logic       chipSelect,
   input  wire logic       pinSelectMode,
   input  wire logic       vccSelHigh,
   input  wire logic       vccSelLow,
   input  wire logic       cardPresent,
   input  wire logic       hostIoIn,
   input  wire logic       cardIoIn,
   output logic            hostIoOut,
   output logic            hostIoOe,
   output logic            cardIoOe,
   output logic [1:0]      vccLevel,
   output logic            cardResetOut,
   output logic            cardStatusOut,
   output logic            cardStatusOe
);

   // ----------------------------------------------------------------
   // limits
   // ----------------------------------------------------------------
   localparam logic [CNT_W-1:0] LIM_5V   = CNT_W'(CYC_5V_P);
   localparam logic [CNT_W-1:0] LIM_3V   = CNT_W'(CYC_3V_P);
   localparam logic [CNT_W-1:0] LIM_PMIN = CNT_W'(CYC_PMIN_P);
   localparam logic [CNT_W-1:0] LIM_PMAX = CNT_W'(CYC_PMAX_P);
   localparam logic [CNT_W-1:0] LIM_HMAX = CNT_W'(CYC_HMAX_P);
   localparam logic [CNT_W-1:0] CNT_SAT  = CNT_W'(CYC_5V_P + 1);

   cssc_regs_s st_reg;
   cssc_regs_s st_next;
   logic       cs;
   logic       cmdEff;
   logic       rstEff;
   logic       fall;
   logic       rise;
   logic       hostLow;
   logic       cardLow;
   logic       active;
   cssc_vcc_e  pinLevel;

   function automatic cssc_vcc_e decodeSel(input logic hi, input logic lo);
      if (hi) begin
         return VCC_5V0;
      end else if (lo) begin
         return VCC_3V0;
      end
      return VCC_1V8;
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_next       = st_reg;
      st_next.syncA = {cardIoIn, hostIoIn, cardPresent, vccSelLow,
                       vccSelHigh, chipSelect, cardResetRequest, supplyCommandN};
      st_next.syncB = st_reg.syncA;
      cs            = st_reg.syncB[SI_CS];
      hostLow       = !st_reg.syncB[SI_HIO];
      cardLow       = !st_reg.syncB[SI_CIO];
      pinLevel      = decodeSel(st_reg.syncB[SI_SELHI], st_reg.syncB[SI_SELLO]);
      // gated inputs freeze while deselected
      if (cs) begin
         st_next.cmdHeld = st_reg.syncB[SI_CMD];
         st_next.rstHeld = st_reg.syncB[SI_RST];
      end
      cmdEff          = cs ? st_reg.syncB[SI_CMD] : st_reg.cmdHeld;
      rstEff          = cs ? st_reg.syncB[SI_RST] : st_reg.rstHeld;
      st_next.cmdPrev = cmdEff;
      fall            = st_reg.cmdPrev && !cmdEff;
      rise            = !st_reg.cmdPrev && cmdEff;
      // edge timer
      if (fall || rise) begin
         st_next.cnt = '0;
      end else if (st_reg.cnt != CNT_SAT) begin
         st_next.cnt = st_reg.cnt + 1'b1;
      end
      case (st_reg.state)
         ST_WAIT: begin
            if (fall) begin
               if (pinSelectMode) begin
                  st_next.state = ST_ACT;
                  st_next.vcc   = pinLevel;
               end else if (st_reg.cnt > LIM_5V) begin
                  st_next.state  = ST_PULSE;
                  st_next.pend5v = 1'b1;
               end else if (st_reg.cnt < LIM_3V) begin
                  st_next.state = ST_ACT;
                  st_next.vcc   = VCC_3V0;
               end else begin
                  st_next.state  = ST_PULSE;
                  st_next.pend5v = 1'b0;
               end
            end
         end
         ST_PULSE: begin
            if (rise) begin
               if (st_reg.cnt >= LIM_PMIN && st_reg.cnt <= LIM_PMAX) begin
                  st_next.state = ST_SEL;
               end else begin
                  st_next.state = ST_WAIT;
               end
            end else if (st_reg.cnt > LIM_PMAX) begin
               st_next.state = ST_ACT;
               st_next.vcc   = st_reg.pend5v ? VCC_5V0 : VCC_3V0;
            end
         end
         ST_SEL: begin
            if (fall) begin
               st_next.state = ST_ACT;
               st_next.vcc   = VCC_3V0;
            end else if (st_reg.cnt > LIM_HMAX) begin
               st_next.state = ST_WAIT;
            end
         end
         ST_ACT: begin
            if (rise) begin
               st_next.state = ST_WAIT;
               st_next.vcc   = VCC_OFF;
            end
         end
         default: begin
            st_next.state = ST_WAIT;
            st_next.vcc   = VCC_OFF;
         end
      endcase
      active = (st_next.state == ST_ACT);
      // data line repeater, first falling side is master
      if (!cs || !active) begin
         st_next.ioMaster = IO_NONE;
      end else begin
         case (st_reg.ioMaster)
            IO_NONE: begin
               if (hostLow) begin
                  st_next.ioMaster = IO_HOST;
               end else if (cardLow) begin
                  st_next.ioMaster = IO_CARD;
               end
            end
            IO_HOST, IO_CARD: begin
               if (!hostLow && !cardLow) begin
                  st_next.ioMaster = IO_NONE;
               end
            end
            default: begin
               st_next.ioMaster = IO_NONE;
            end
         endcase
      end
      st_next.hostIoOut = 1'b0;
      st_next.cardIoOe  = (st_next.ioMaster == IO_HOST) && hostLow;
      st_next.hostIoOe  = (st_next.ioMaster == IO_CARD) && cardLow;
      st_next.cardRst   = active && rstEff;
      st_next.statOut   = st_reg.syncB[SI_PRES];
      st_next.statOe    = cs;
   end

   // ----------------------------------------------------------------
   // state register, clock never gated by chip select
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_reg <= '{syncA: SYNC_RST, syncB: SYNC_RST, cmdPrev: 1'b1, cmdHeld: 1'b1,
                     rstHeld: 1'b0, cnt: '0, state: ST_WAIT, pend5v: 1'b0,
                     vcc: VCC_OFF, ioMaster: IO_NONE, hostIoOut: 1'b0,
                     hostIoOe: 1'b0, cardIoOe: 1'b0, cardRst: 1'b0,
                     statOut: 1'b0, statOe: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign hostIoOut     = st_reg.hostIoOut;
   assign hostIoOe      = st_reg.hostIoOe;
   assign cardIoOe      = st_reg.cardIoOe;
   assign vccLevel      = st_reg.vcc;
   assign cardResetOut  = st_reg.cardRst;
   assign cardStatusOut = st_reg.statOut;
   assign cardStatusOe  = st_reg.statOe;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   sequence selEntered;
      st_reg.state == ST_PULSE ##1 st_reg.state == ST_SEL;
   endsequence

   a_cnt_restart: assert property ((fall || rise) |=> st_reg.cnt == '0)
      else $error("timer not restarted on command edge");
   a_long_high_5v: assert property ((st_reg.state == ST_WAIT && fall && !pinSelectMode
      && st_reg.cnt > LIM_5V) |=> st_reg.state == ST_PULSE && st_reg.pend5v)
      else $error("long high time did not hold 5 V");
   a_short_high_3v: assert property ((st_reg.state == ST_WAIT && fall && !pinSelectMode
      && st_reg.cnt < LIM_3V) |=> st_reg.state == ST_ACT && st_reg.vcc == VCC_3V0)
      else $error("short high time did not give 3 V");
   a_pin_level: assert property ((st_reg.state == ST_WAIT && fall && pinSelectMode)
      |=> st_reg.state == ST_ACT && st_reg.vcc == $past(pinLevel))
      else $error("select pin level not applied");
   a_sel_pulse_3v: assert property ((selEntered ##0 (!fall && st_reg.cnt <= LIM_HMAX))
      |=> st_reg.state == ST_SEL || st_reg.state == ST_WAIT)
      else $error("selection pulse activated card");
   a_sel_fall_3v: assert property ((st_reg.state == ST_SEL && fall)
      |=> st_reg.state == ST_ACT && st_reg.vcc == VCC_3V0)
      else $error("selection did not give 3 V");
   a_cs_hold: assert property ((!cs && st_reg.state == ST_ACT)
      |=> st_reg.state == ST_ACT && $stable(st_reg.vcc))
      else $error("session changed while deselected");
   a_cs_float_io: assert property (!cs |=> (!hostIoOe && !cardIoOe) ##1 (!hostIoOe || $past(cs)))
      else $error("data line driven while deselected");
   a_cs_float_stat: assert property (!cs |=> !cardStatusOe)
      else $error("status driven while deselected");
   a_status_pres: assert property (cs |=> cardStatusOut == $past(st_reg.syncB[SI_PRES]))
      else $error("status does not follow presence");

endmodule

// file: tb/cssc_host_model.sv
// far side model: host command, reset, chip select, select pin, mode strap, data pulls
// assumes the bench calls its tasks; all changes land on the falling clock edge
`timescale 1ns/1ps
module cssc_host_model
   import cssc_pkg::*;
#(
   parameter int unsigned LOW_N = 40,
   parameter int unsigned GAP_N = 50
)(
   input  wire logic clk,
   output logic      supplyCommandN,
   output logic      cardResetRequest,
   output logic      chipSelect,
   output logic      vccSelHigh,
   output logic      vccSelLow,
   output logic      pinSelectMode,
   output logic      cardPresent,
   output logic      hostPullLow,
   output logic      cardPullLow
);
   // ----------------------------------------------------------------
   // idle levels
   // ----------------------------------------------------------------
   initial begin
      supplyCommandN   = 1'b1;
      cardResetRequest = 1'b0;
      chipSelect       = 1'b1;
      vccSelHigh       = 1'b0;
      vccSelLow        = 1'b0;
      pinSelectMode    = 1'b0;
      cardPresent      = 1'b0;
      hostPullLow      = 1'b0;
      cardPullLow      = 1'b0;
   end

   // ----------------------------------------------------------------
   // pin tasks
   // ----------------------------------------------------------------
   // level held n cycles; high level ends a session
   task automatic cmd(input logic v, input int n);
      @(negedge clk) supplyCommandN = v;
      repeat (n - 1) @(negedge clk);
   endtask

   // selection pulse low part, inside 200..700 us window
   task automatic sel_low();
      cmd(1'b0, LOW_N);
   endtask

   // selection gap high part, shorter than 15 ms
   task automatic sel_gap();
      cmd(1'b1, GAP_N);
   endtask

   task automatic rst_req(input logic v);
      @(negedge clk) cardResetRequest = v;
   endtask

   task automatic cs(input logic v);
      @(negedge clk) chipSelect = v;
   endtask

   // strap choosing pin or timed supply selection
   task automatic mode(input logic v);
      @(negedge clk) pinSelectMode = v;
   endtask

   task automatic card(input logic v);
      @(negedge clk) cardPresent = v;
   endtask

   // open-drain pulls on host and card data lines
   task automatic pull(input logic h, input logic c);
      @(negedge clk) begin
         hostPullLow = h;
         cardPullLow = c;
      end
   endtask

   // select pin changed only between sessions
   task automatic sel(input logic hi, input logic lo);
      @(negedge clk) begin
         vccSelHigh = hi;
         vccSelLow  = lo;
      end
   endtask
endmodule

// file: tb/tb_cssc_top.sv
// self-checking bench of the supply select and chip select block
// assumes small timing parameters; host model drives the command side
`timescale 1ns/1ps
module tb_cssc_top;
   import cssc_pkg::*;
   logic       clk = 1'b0;
   logic       nrst;
   logic       pinSelectMode, cardPresent, hostPullLow, cardPullLow;
   logic       supplyCommandN, cardResetRequest, chipSelect, vccSelHigh, vccSelLow;
   logic       hostIoIn, cardIoIn, hostIoOut, hostIoOe, cardIoOe;
   logic [1:0] vccLevel;
   logic       cardResetOut, cardStatusOut, cardStatusOe;
   int         errCount = 0;
   int         comparisons = 0;
   int         hi [2] = '{200, 400};

   always #10 clk = ~clk;
   // open-drain wires with pull-ups
   assign hostIoIn = ~(hostPullLow | hostIoOe);
   assign cardIoIn = ~(cardPullLow | cardIoOe);

   // ----------------------------------------------------------------
   // instances
   // ----------------------------------------------------------------
   cssc_host_model i_cssc_host_model (.clk(clk), .supplyCommandN(supplyCommandN),
      .cardResetRequest(cardResetRequest), .chipSelect(chipSelect),
      .vccSelHigh(vccSelHigh), .vccSelLow(vccSelLow), .pinSelectMode(pinSelectMode),
      .cardPresent(cardPresent), .hostPullLow(hostPullLow), .cardPullLow(cardPullLow));
   cssc_top #(.CYC_5V_P(300), .CYC_3V_P(150), .CYC_PMIN_P(20), .CYC_PMAX_P(70),
      .CYC_HMAX_P(150)) i_cssc_top (.clk(clk), .nrst(nrst),
      .supplyCommandN(supplyCommandN), .cardResetRequest(cardResetRequest),
      .chipSelect(chipSelect), .pinSelectMode(pinSelectMode), .vccSelHigh(vccSelHigh),
      .vccSelLow(vccSelLow), .cardPresent(cardPresent), .hostIoIn(hostIoIn),
      .cardIoIn(cardIoIn), .hostIoOut(hostIoOut), .hostIoOe(hostIoOe),
      .cardIoOe(cardIoOe), .vccLevel(vccLevel), .cardResetOut(cardResetOut),
      .cardStatusOut(cardStatusOut), .cardStatusOe(cardStatusOe));

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [1:0] e, input logic [1:0] g);
      comparisons++;
      if (g !== e) begin
         errCount++;
         $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, errCount);
      if (errCount == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      nrst = 1'b0;
      cyc(4);
      nrst = 1'b1;
      cyc(5);
      chk("statusOut", 2'h0, {1'b0, cardStatusOut});
      chk("statusOe", 2'h1, {1'b0, cardStatusOe});
      i_cssc_host_model.card(1'b1);
      cyc(5);
      chk("statusOut", 2'h1, {1'b0, cardStatusOut});
      i_cssc_host_model.cmd(1'b1, 400);
      i_cssc_host_model.cmd(1'b0, 4);
      chk("vccHeld", 2'h0, vccLevel);
      cyc(80);
      chk("vcc5", 2'h1, vccLevel);
      i_cssc_host_model.cmd(1'b1, 5);
      chk("vccOff", 2'h0, vccLevel);
      i_cssc_host_model.cmd(1'b1, 45);
      i_cssc_host_model.cmd(1'b0, 5);
      chk("vcc3", 2'h2, vccLevel);
      for (int k = 0; k < 2; k++) begin
         i_cssc_host_model.cmd(1'b1, hi[k]);
         i_cssc_host_model.sel_low();
         chk("vccPulse", 2'h0, vccLevel);
         i_cssc_host_model.sel_gap();
         i_cssc_host_model.cmd(1'b0, 5);
         chk("vccSel3", 2'h2, vccLevel);
      end
      i_cssc_host_model.pull(1'b1, 1'b0);
      cyc(5);
      chk("cardIoOe", 2'h1, {1'b0, cardIoOe});
      chk("hostIoOeSlave", 2'h0, {1'b0, hostIoOe});
      chk("hostIoOut", 2'h0, {1'b0, hostIoOut});
      i_cssc_host_model.pull(1'b0, 1'b0);
      cyc(5);
      chk("cardIoOe", 2'h0, {1'b0, cardIoOe});
      i_cssc_host_model.rst_req(1'b1);
      cyc(5);
      chk("cardRst", 2'h1, {1'b0, cardResetOut});
      i_cssc_host_model.pull(1'b0, 1'b1);
      cyc(5);
      chk("hostIoOe", 2'h1, {1'b0, hostIoOe});
      i_cssc_host_model.cs(1'b0);
      cyc(5);
      chk("hostIoOe", 2'h0, {1'b0, hostIoOe});
      chk("statusOe", 2'h0, {1'b0, cardStatusOe});
      chk("cardIoOe", 2'h0, {1'b0, cardIoOe});
      i_cssc_host_model.pull(1'b0, 1'b0);
      i_cssc_host_model.cmd(1'b1, 5);
      i_cssc_host_model.rst_req(1'b0);
      cyc(5);
      chk("vccFrozen", 2'h2, vccLevel);
      chk("rstFrozen", 2'h1, {1'b0, cardResetOut});
      i_cssc_host_model.cs(1'b1);
      cyc(6);
      chk("vccResume", 2'h0, vccLevel);
      chk("statusOe", 2'h1, {1'b0, cardStatusOe});
      chk("cardRst", 2'h0, {1'b0, cardResetOut});
      i_cssc_host_model.mode(1'b1);
      for (int k = 0; k < 3; k++) begin
         i_cssc_host_model.sel(k == 0, k == 1);
         i_cssc_host_model.cmd(1'b1, 10);
         i_cssc_host_model.cmd(1'b0, 5);
         chk("vccPin", 2'(k + 1), vccLevel);
         i_cssc_host_model.cmd(1'b1, 5);
      end
      test_done();
   end

   initial begin
      repeat (5000) @(posedge clk);
      errCount++;
      $display("MISMATCH watchdog expected done seen running");
      test_done();
   end
endmodule
